// ==== design/jss_top.v ====
`timescale 1ns/1ps
`include "jss_defs.vh"
module jss_top #(
    parameter TICK_CYC = `JSS_TICK_CYC,
    parameter TICKS_PER_S = `JSS_TICKS_PER_S
) (
    input wire mclk_in, // 125 MHz clock
    input wire rstn_in, // Async reset, active low
    input wire [5:0] recipe_lines_in, // Recipe trigger lines from controller
    input wire stop_in, // Abort request from controller
    input wire button_in, // Panel trigger button, high when pressed
    input wire [3:0] addr_in, // Register address
    input wire [15:0] wdata_in, // Register write data
    input wire wr_in, // Write strobe
    input wire rd_in, // Read strobe
    output reg [15:0] rdata_out, // Read data, cycle after strobe
    output reg valve_out, // Jet valve drive, high is open
    output reg firing_out, // Firing indicator
    output reg busy_out, // Busy toward controller
    output reg heater_en_out, // Heater enable
    output reg comp_on_out // Compensation timer running
);
    localparam ST_IDLE = 2'h0;
    localparam ST_OPEN = 2'h1;
    localparam ST_CLOSED = 2'h2;

    reg rst_m, rst_s;
    reg [5:0] lines_m, lines_s, lines_d;
    reg stop_m, stop_s, btn_m, btn_s, btn_d;
    reg [1:0] slot_mode;
    reg [15:0] slot_open [0:5];
    reg [15:0] slot_closed [0:5];
    reg [15:0] slot_drops [0:5];
    reg [15:0] slot_press [0:5];
    reg [15:0] slot_extra [0:5];
    reg [15:0] slot_comp [0:5];
    reg [5:0] slot_lvl;
    reg [2:0] sel;
    reg [15:0] idle_extra, after_s, htimer_min, serial_cfg;
    reg man_valve;
    reg [31:0] tally, life;
    reg [31:0] comp_s;
    reg [1:0] state;
    reg [15:0] tick_cnt;
    reg [15:0] ivl;
    reg [15:0] left;
    reg held, first, idle_hit, running;
    reg [15:0] sub_s;
    reg [31:0] idle_s;
    reg [15:0] comp_sub;
    // Idle seconds are timed from the last drop, not from the free-running second
    reg [15:0] idle_sub;
    // Slot latched at trigger so every drop of one run uses one recipe
    reg [2:0] run_slot;
    wire rst_n = rst_s;
    wire tick = (tick_cnt == TICK_CYC - 1);
    wire sec_tick = tick && (sub_s == TICKS_PER_S - 1);
    wire idle_sec = tick && (idle_sub == TICKS_PER_S - 1);
    wire [2:0] line_idx;
    wire line_rise;
    wire btn_rise = btn_s & ~btn_d;
    wire drop_done;
    integer i;

    // Lowest numbered line wins when several rise together
    function [2:0] jss_first;
        input [5:0] v;
        integer k;
        begin
            jss_first = 3'h0;
            for (k = 5; k >= 0; k = k - 1)
                if (v[k])
                    jss_first = k[2:0];
        end
    endfunction
    assign line_idx = jss_first(lines_s & ~lines_d);
    assign line_rise = |(lines_s & ~lines_d);
    assign drop_done = (state == ST_CLOSED) && tick && (ivl <= 16'h0001);

    // Reset release through two flops
    always @(posedge mclk_in or negedge rstn_in)
    begin
        if (!rstn_in)
        begin
            rst_m <= 1'b0;
            rst_s <= 1'b0;
        end
        else
        begin
            rst_m <= 1'b1;
            rst_s <= rst_m;
        end
    end

    // Pin synchronisers, then edge history from the second stage only
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            lines_m <= 6'h00;
            lines_s <= 6'h00;
            lines_d <= 6'h00;
            stop_m <= 1'b0;
            stop_s <= 1'b0;
            btn_m <= 1'b0;
            btn_s <= 1'b0;
            btn_d <= 1'b0;
        end
        else
        begin
            lines_m <= recipe_lines_in;
            lines_s <= lines_m;
            lines_d <= lines_s;
            stop_m <= stop_in;
            stop_s <= stop_m;
            btn_m <= button_in;
            btn_s <= btn_m;
            btn_d <= btn_s;
        end
    end

    // 0.1 ms tick and one-second tick
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            tick_cnt <= 16'h0000;
            sub_s <= 16'h0000;
        end
        else
        begin
            tick_cnt <= tick ? 16'h0000 : tick_cnt + 16'h0001;
            if (tick)
                sub_s <= (sub_s == TICKS_PER_S - 1) ? 16'h0000 : sub_s + 16'h0001;
        end
    end

    // Register writes; recipe fields go to the selected slot
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            for (i = 0; i < `JSS_SLOTS; i = i + 1)
            begin
                slot_open[i] <= 16'h000a;
                slot_closed[i] <= 16'h000a;
                slot_drops[i] <= 16'h0001;
                slot_press[i] <= 16'h00c8;
                slot_extra[i] <= 16'h0000;
                slot_comp[i] <= 16'h0000;
            end
            slot_lvl <= 6'h00;
            sel <= 3'h0;
            idle_extra <= 16'h0000;
            after_s <= 16'h0000;
            htimer_min <= 16'h0000;
            serial_cfg <= `JSS_SER_RESET;
            man_valve <= 1'b0;
        end
        else if (wr_in)
        begin
            case (addr_in)
                `JSS_A_MODE: slot_lvl[sel] <= wdata_in[0];
                `JSS_A_OPEN: slot_open[sel] <= wdata_in;
                `JSS_A_CLOSED: slot_closed[sel] <= wdata_in;
                `JSS_A_DROPS: slot_drops[sel] <= wdata_in;
                `JSS_A_PRESS: slot_press[sel] <= wdata_in;
                `JSS_A_EXTRA: slot_extra[sel] <= wdata_in;
                `JSS_A_COMPCFG: slot_comp[sel] <= wdata_in;
                `JSS_A_SEL: sel <= (wdata_in[2:0] < 3'h6) ? wdata_in[2:0] : sel;
                `JSS_A_IDLEX: idle_extra <= wdata_in;
                `JSS_A_AFTER: after_s <= wdata_in;
                `JSS_A_HTIMER: htimer_min <= wdata_in;
                // Baud code in bits 2:0, parity in 4:3, bit 5 high selects 7 data bits
                // Out-of-range codes fall back to the default rather than a dead setting
                `JSS_A_SERIAL: serial_cfg <= {10'h000, wdata_in[5], wdata_in[4:3] == 2'h3 ? 2'h0 : wdata_in[4:3],
                    (wdata_in[2:0] > 3'h4) ? 3'h0 : wdata_in[2:0]};
                `JSS_A_CTRL:
                begin
                    if (wdata_in[`JSS_C_VSET])
                        man_valve <= wdata_in[`JSS_C_VALVE];
                    if (wdata_in[`JSS_C_PUP])
                        slot_press[sel] <= slot_press[sel] + 16'h0001;
                    else if (wdata_in[`JSS_C_PDN] && slot_press[sel] != 16'h0000)
                        slot_press[sel] <= slot_press[sel] - 16'h0001;
                end
                default: sel <= sel;
            endcase
        end
    end

    // Firing sequencer: open interval then closed interval per drop
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            state <= ST_IDLE;
            ivl <= 16'h0000;
            left <= 16'h0000;
            held <= 1'b0;
            first <= 1'b0;
            running <= 1'b0;
            run_slot <= 3'h0;
        end
        // Stop wins over any trigger arriving in the same cycle
        else if (stop_s)
        begin
            state <= ST_IDLE;
            running <= 1'b0;
        end
        else
        begin
            case (state)
                ST_IDLE:
                    if (btn_rise || line_rise)
                    begin
                        // Button always counts; held mode only from the lines
                        held <= line_rise && !btn_rise && slot_lvl[line_rise ? line_idx : sel];
                        first <= 1'b1;
                        run_slot <= (line_rise && !btn_rise) ? line_idx : sel;
                        left <= slot_drops[line_rise && !btn_rise ? line_idx : sel];
                        ivl <= slot_open[line_rise && !btn_rise ? line_idx : sel]
                            + slot_extra[line_rise && !btn_rise ? line_idx : sel]
                            + (idle_hit ? idle_extra : 16'h0000);
                        running <= 1'b1;
                        state <= ST_OPEN;
                    end
                ST_OPEN:
                    if (tick)
                    begin
                        if (ivl <= 16'h0001)
                        begin
                            ivl <= slot_closed[run_slot];
                            state <= ST_CLOSED;
                        end
                        else
                            ivl <= ivl - 16'h0001;
                    end
                ST_CLOSED:
                    if (tick)
                    begin
                        if (ivl > 16'h0001)
                            ivl <= ivl - 16'h0001;
                        else if (held ? !(|lines_s) : (left <= 16'h0001))
                        begin
                            state <= ST_IDLE;
                            running <= 1'b0;
                        end
                        else
                        begin
                            first <= 1'b0;
                            left <= left - 16'h0001;
                            ivl <= slot_open[run_slot] + (held ? 16'h0000 : slot_extra[run_slot]);
                            state <= ST_OPEN;
                        end
                    end
                default: state <= ST_IDLE;
            endcase
        end
    end

    // Held-mode flag of the last run, copied for the status read
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            slot_mode <= 2'h0;
        else
            slot_mode <= {1'b0, held};
    end

    // Idle timing, tallies and compensation timer
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            idle_s <= 32'h00000000;
            idle_sub <= 16'h0000;
            idle_hit <= 1'b0;
            tally <= 32'h00000000;
            life <= 32'h00000000;
            comp_s <= 32'h00000000;
            comp_sub <= 16'h0000;
            comp_on_out <= 1'b0;
            heater_en_out <= 1'b1;
        end
        else
        begin
            if (drop_done)
            begin
                idle_s <= 32'h00000000;
                idle_sub <= 16'h0000;
                idle_hit <= 1'b0;
                heater_en_out <= 1'b1;
            end
            else if (!running && tick)
            begin
                // Own sub-counter, so a short idle never counts as a whole second
                idle_sub <= (idle_sub == TICKS_PER_S - 1) ? 16'h0000 : idle_sub + 16'h0001;
                if (idle_sec)
                begin
                    idle_s <= idle_s + 32'h00000001;
                    if (idle_s + 32'h00000001 >= {16'h0000, after_s})
                        idle_hit <= 1'b1;
                    if (htimer_min != 16'h0000 &&
                        idle_s + 32'h00000001 >= htimer_min * `JSS_S_PER_MIN)
                        heater_en_out <= 1'b0;
                end
            end
            if (wr_in && addr_in == `JSS_A_CTRL && wdata_in[`JSS_C_CLRTALLY])
                tally <= drop_done ? 32'h00000001 : 32'h00000000;
            else if (drop_done)
                tally <= tally + 32'h00000001;
            if (drop_done)
                life <= life + 32'h00000001;
            if (wr_in && addr_in == `JSS_A_CTRL && wdata_in[`JSS_C_CSTOP])
            begin
                comp_on_out <= 1'b0;
                comp_s <= 32'h00000000;
                comp_sub <= 16'h0000;
            end
            else if (wr_in && addr_in == `JSS_A_CTRL && wdata_in[`JSS_C_CSTART])
                comp_on_out <= 1'b1;
            else if (comp_on_out && sec_tick)
                comp_s <= comp_s + 32'h00000001;
        end
    end

    // Valve, indicator and busy outputs
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
        begin
            valve_out <= 1'b0;
            firing_out <= 1'b0;
            busy_out <= 1'b0;
        end
        else
        begin
            valve_out <= running ? (state == ST_OPEN) : man_valve;
            firing_out <= running;
            busy_out <= running;
        end
    end

    // Read port, data valid the cycle after the strobe
    always @(posedge mclk_in or negedge rst_n)
    begin
        if (!rst_n)
            rdata_out <= 16'h0000;
        else if (rd_in)
        begin
            case (addr_in)
                `JSS_A_MODE: rdata_out <= {15'h0000, slot_lvl[sel]};
                `JSS_A_OPEN: rdata_out <= slot_open[sel];
                `JSS_A_CLOSED: rdata_out <= slot_closed[sel];
                `JSS_A_DROPS: rdata_out <= slot_drops[sel];
                `JSS_A_PRESS: rdata_out <= slot_press[sel];
                `JSS_A_EXTRA: rdata_out <= slot_extra[sel];
                `JSS_A_COMPCFG: rdata_out <= slot_comp[sel];
                `JSS_A_SEL: rdata_out <= {13'h0000, sel};
                `JSS_A_IDLEX: rdata_out <= idle_extra;
                `JSS_A_AFTER: rdata_out <= after_s;
                `JSS_A_HTIMER: rdata_out <= htimer_min;
                `JSS_A_SERIAL: rdata_out <= serial_cfg;
                `JSS_A_CTRL: rdata_out <= {15'h0000, man_valve};
                `JSS_A_STATUS: rdata_out <= {comp_s[10:0], heater_en_out, comp_on_out, valve_out, slot_mode[0], running};
                `JSS_A_TALLY: rdata_out <= tally[15:0];
                default: rdata_out <= life[15:0];
            endcase
        end
    end
endmodule // jss_top

// ==== design/jss_defs.vh ====
// How it works
// - Panel button fires selected recipe immediately
// - Firing indicator high while firing, low idle
// - Six recipe slots; idle, heater and serial settings shared
// - Burst mode gives exact drop count
// - Held mode fires while trigger held
// - Button in held mode gives counted burst
// - Open interval in 0.1 ms steps
// - Closed interval in 0.1 ms steps
// - Extra open time: every drop burst, first held
// - Idle extra added after idle threshold
// - Idle threshold counted in whole seconds
// - Heater off after idle minutes; zero disables
// - Resettable drop tally, confirmed clear only
// - Lifetime drop tally never cleared
// - Serial defaults 115200 8N1, other options
// - Manual valve open/close with position report
// - Comp timer start; stop clears and reports off
// - Pressure setpoint steps by 0.1 psi
// - Busy output while dispensing
// - Stop input aborts dispense sequence
`ifndef JSS_DEFS_VH
`define JSS_DEFS_VH
`define JSS_CLK_MHZ 125
`define JSS_TICK_US 100
`define JSS_TICK_CYC (`JSS_CLK_MHZ * `JSS_TICK_US)
`define JSS_TICKS_PER_S 10000
`define JSS_S_PER_MIN 60
`define JSS_SLOTS 6
`define JSS_A_MODE 4'h0
`define JSS_A_OPEN 4'h1
`define JSS_A_CLOSED 4'h2
`define JSS_A_DROPS 4'h3
`define JSS_A_PRESS 4'h4
`define JSS_A_EXTRA 4'h5
`define JSS_A_COMPCFG 4'h6
`define JSS_A_SEL 4'h7
`define JSS_A_IDLEX 4'h8
`define JSS_A_AFTER 4'h9
`define JSS_A_HTIMER 4'ha
`define JSS_A_SERIAL 4'hb
`define JSS_A_CTRL 4'hc
`define JSS_A_STATUS 4'hd
`define JSS_A_TALLY 4'he
`define JSS_A_LIFE 4'hf
`define JSS_SER_RESET 16'h0000
`define JSS_C_VALVE 0
`define JSS_C_VSET 1
`define JSS_C_CLRTALLY 2
`define JSS_C_CSTART 3
`define JSS_C_CSTOP 4
`define JSS_C_PUP 5
`define JSS_C_PDN 6
`endif

// ==== testbench/jss_top_props.sv ====
`timescale 1ns/1ps
`include "jss_defs.vh"
module jss_top_props #(
    parameter TICK_CYC = 4,
    parameter TICKS_PER_S = 10
) (
    input wire mclk_in, // Clock
    input wire rstn_in, // Reset, active low
    input wire [5:0] recipe_lines_in, // Trigger lines
    input wire stop_in, // Abort
    input wire button_in, // Panel button
    input wire [3:0] addr_in, // Address
    input wire [15:0] wdata_in, // Write data
    input wire wr_in, // Write strobe
    input wire rd_in, // Read strobe
    input wire [15:0] rdata_out, // Read data
    input wire valve_out, // Valve drive
    input wire firing_out, // Indicator
    input wire busy_out, // Busy
    input wire heater_en_out, // Heater enable
    input wire comp_on_out // Comp running
);
    // Control writes decoded once; the strobe lasts one cycle
    wire ctrl_wr;
    assign ctrl_wr = wr_in && (addr_in == `JSS_A_CTRL);
    default clocking cb @(posedge mclk_in); endclocking
    default disable iff (!rstn_in);
    // Triggers are synchronised, so a few cycles of latency are allowed
    AST_BUSY_FIRING: assert property (busy_out == firing_out)
        else $error("busy differs from firing indicator");
    AST_STOP_ABORT: assert property (stop_in [*8] |-> !firing_out)
        else $error("firing continues under held stop");
    AST_BUTTON_FIRES: assert property ($rose(button_in) && !firing_out && !stop_in ##1 button_in [*5]
        |-> ##[0:3] firing_out) else $error("button press did not start firing");
    AST_LINE_FIRES: assert property ($rose(recipe_lines_in[0]) && !firing_out && !stop_in
        ##1 recipe_lines_in[0] [*5] |-> ##[0:3] firing_out) else $error("line did not start firing");
    AST_VALVE_FOLLOWS: assert property ($rose(firing_out) |-> ##[0:2] valve_out)
        else $error("valve did not open after firing start");
    AST_IDLE_CLOSED: assert property ($fell(firing_out) |-> !valve_out)
        else $error("valve open when sequencer went idle");
    AST_RDATA_HOLD: assert property (!rd_in |=> $stable(rdata_out))
        else $error("read data changed without a read");
    AST_COMP_START: assert property (ctrl_wr && wdata_in[`JSS_C_CSTART] && !wdata_in[`JSS_C_CSTOP]
        |-> ##[1:3] comp_on_out) else $error("comp timer did not start");
    AST_COMP_STOP: assert property (ctrl_wr && wdata_in[`JSS_C_CSTOP] |-> ##[1:3] !comp_on_out)
        else $error("comp timer did not stop");
    AST_MAN_VALVE: assert property (ctrl_wr && wdata_in[`JSS_C_VSET] && wdata_in[`JSS_C_VALVE] && !busy_out
        |-> ##[1:3] valve_out) else $error("manual valve open ignored");
    COV_FIRE: cover property ($rose(firing_out));
    COV_ABORT: cover property (stop_in && firing_out);
    COV_HEATER: cover property ($fell(heater_en_out));
endmodule // jss_top_props

bind jss_top jss_top_props #(.TICK_CYC(TICK_CYC), .TICKS_PER_S(TICKS_PER_S)) i_jss_top_props (
    .mclk_in(mclk_in), .rstn_in(rstn_in), .recipe_lines_in(recipe_lines_in), .stop_in(stop_in),
    .button_in(button_in), .addr_in(addr_in), .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in),
    .rdata_out(rdata_out), .valve_out(valve_out), .firing_out(firing_out), .busy_out(busy_out),
    .heater_en_out(heater_en_out), .comp_on_out(comp_on_out));

// ==== testbench/jss_robot.sv ====
`timescale 1ns/1ps
module jss_robot (
    input wire mclk_in, // Shared clock
    output logic [5:0] lines_out, // Six recipe trigger lines
    output logic stop_out // Abort request
);
    // Outputs are driven levels at all times, never left floating
    initial
    begin
        lines_out = 6'h00;
        stop_out = 1'b0;
    end
    // Hold one line high; a short hold is a pulse, a long one a held trigger
    task automatic hold_line(input int k, input int cyc);
        @(posedge mclk_in);
        lines_out[k] <= 1'b1;
        repeat (cyc) @(posedge mclk_in);
        lines_out[k] <= 1'b0;
    endtask
    // Abort pulse toward the sequencer
    task automatic pulse_stop(input int cyc);
        @(posedge mclk_in);
        stop_out <= 1'b1;
        repeat (cyc) @(posedge mclk_in);
        stop_out <= 1'b0;
    endtask
endmodule // jss_robot

// ==== testbench/testbench.sv ====
`timescale 1ns/1ps
`include "jss_defs.vh"
module testbench;
    localparam TC = 4;
    logic mclk_in = 1'b0, rstn_in = 1'b0, button_in = 1'b0, wr_in = 1'b0, rd_in = 1'b0;
    logic [3:0] addr_in = 4'h0;
    logic [15:0] wdata_in = 16'h0000, rdata_out, d;
    logic [5:0] lines;
    logic stop, valve_out, firing_out, busy_out, heater_en_out, comp_on_out;
    int err_total = 0, checks = 0, oc = 0, cc = 0;
    int opens[$], closes[$];
    always #4 mclk_in = ~mclk_in;
    jss_robot i_jss_robot (.mclk_in(mclk_in), .lines_out(lines), .stop_out(stop));
    // Tick shortened to 4 cycles and one second to 10 ticks to keep the run short
    jss_top #(.TICK_CYC(TC), .TICKS_PER_S(10)) i_jss_top (.mclk_in(mclk_in), .rstn_in(rstn_in),
        .recipe_lines_in(lines), .stop_in(stop), .button_in(button_in), .addr_in(addr_in),
        .wdata_in(wdata_in), .wr_in(wr_in), .rd_in(rd_in), .rdata_out(rdata_out), .valve_out(valve_out),
        .firing_out(firing_out), .busy_out(busy_out), .heater_en_out(heater_en_out), .comp_on_out(comp_on_out));
    // Valve open lengths, and closed lengths only between drops of one sequence
    always @(posedge mclk_in)
    begin
        if (valve_out && cc > 0)
            closes.push_back(cc);
        cc = (!valve_out && firing_out) ? cc + 1 : 0;
        if (!valve_out && oc > 0)
            opens.push_back(oc);
        oc = valve_out ? oc + 1 : 0;
    end
    task automatic give_verdict;
        $display("checks %0d err_total %0d", checks, err_total);
        if (err_total == 0 && checks > 0)
            $display("Result: passed");
        else
            $display("Result: failed");
        $finish;
    endtask
    task automatic check(input string nm, input logic [31:0] seen, input logic [31:0] exp);
        checks++;
        if (seen !== exp)
        begin
            err_total++;
            $display("ERROR %s expected %0h seen %0h", nm, exp, seen);
        end
    endtask
    task automatic wr(input logic [3:0] a, input logic [15:0] v);
        @(posedge mclk_in);
        wr_in <= 1'b1;
        addr_in <= a;
        wdata_in <= v;
        @(posedge mclk_in);
        wr_in <= 1'b0;
    endtask
    // Read data are sampled in the cycle after the strobe
    task automatic rdck(input string nm, input logic [3:0] a, input logic [15:0] e);
        @(posedge mclk_in);
        rd_in <= 1'b1;
        addr_in <= a;
        @(posedge mclk_in);
        rd_in <= 1'b0;
        #1 d = rdata_out;
        check(nm, {16'h0000, d}, {16'h0000, e});
    endtask
    // Bounded wait for the firing indicator; a hang ends the run
    task automatic wait_fire(input logic v, input int lim);
        int n;
        n = 0;
        while (firing_out !== v && n < lim)
        begin
            @(posedge mclk_in);
            n++;
        end
        if (n >= lim)
        begin
            err_total++;
            $display("ERROR firing wait expected %0h", v);
            give_verdict();
        end
    endtask
    function automatic int tk(input int c);
        return (c + TC - 1) / TC;
    endfunction
    task automatic slot(input logic [15:0] s, m, op, cl, dr, ex);
        wr(`JSS_A_SEL, s);
        wr(`JSS_A_MODE, m);
        wr(`JSS_A_OPEN, op);
        wr(`JSS_A_CLOSED, cl);
        wr(`JSS_A_DROPS, dr);
        wr(`JSS_A_EXTRA, ex);
    endtask
    task automatic press_run;
        opens.delete();
        closes.delete();
        @(posedge mclk_in);
        button_in <= 1'b1;
        wait_fire(1'b1, 20);
        repeat (4) @(posedge mclk_in);
        button_in <= 1'b0;
        wait_fire(1'b0, 3000);
    endtask
    task automatic t_burst;
        slot(16'h0002, 16'h0000, 16'h0003, 16'h0002, 16'h0003, 16'h0001);
        press_run();
        check("drops", opens.size(), 3);
        check("open0", tk(opens[0]), 4);
        check("open2", tk(opens[2]), 4);
        check("closed", tk(closes[0]), 2);
        check("gaps", closes.size(), 2);
        check("busy", 32'(busy_out), 0);
        rdck("tally", `JSS_A_TALLY, 16'h0003);
        wr(`JSS_A_CTRL, 16'h0004);
        rdck("tally0", `JSS_A_TALLY, 16'h0000);
        rdck("life", `JSS_A_LIFE, 16'h0003);
        wr(`JSS_A_SEL, 16'h0006);
        rdck("sel", `JSS_A_SEL, 16'h0002);
        rdck("open", `JSS_A_OPEN, 16'h0003);
    endtask
    // Held mode from a line, then the panel button in held mode
    task automatic t_held;
        slot(16'h0000, 16'h0001, 16'h0002, 16'h0002, 16'h0002, 16'h0002);
        opens.delete();
        fork
            i_jss_robot.hold_line(0, 100);
            begin
                wait_fire(1'b1, 20);
                wait_fire(1'b0, 3000);
            end
        join
        check("many", 32'(opens.size() > 2), 1);
        check("first", tk(opens[0]), 4);
        check("later", tk(opens[1]), 2);
        press_run();
        check("btn", opens.size(), 2);
    endtask
    task automatic t_stop;
        slot(16'h0000, 16'h0000, 16'h0003, 16'h0002, 16'h0014, 16'h0000);
        opens.delete();
        fork
            i_jss_robot.hold_line(0, 6);
            begin
                wait_fire(1'b1, 20);
                repeat (50) @(posedge mclk_in);
                i_jss_robot.pulse_stop(10);
                wait_fire(1'b0, 20);
            end
        join
        check("cut", 32'(opens.size() < 20), 1);
    endtask
    // Idle extra after the idle threshold, first drop only, counter restarts on a drop
    task automatic t_idle;
        wr(`JSS_A_IDLEX, 16'h0003);
        wr(`JSS_A_AFTER, 16'h0001);
        slot(16'h0002, 16'h0000, 16'h0003, 16'h0002, 16'h0002, 16'h0000);
        repeat (100) @(posedge mclk_in);
        press_run();
        check("idle0", tk(opens[0]), 6);
        check("idle1", tk(opens[1]), 3);
        press_run();
        check("again", tk(opens[0]), 3);
        wr(`JSS_A_IDLEX, 16'h0000);
    endtask
    // One minute is 2400 cycles at the shortened tick
    task automatic t_heater;
        repeat (2550) @(posedge mclk_in);
        check("hoff0", 32'(heater_en_out), 1);
        press_run();
        wr(`JSS_A_HTIMER, 16'h0001);
        repeat (2150) @(posedge mclk_in);
        check("hon", 32'(heater_en_out), 1);
        repeat (400) @(posedge mclk_in);
        check("hoff", 32'(heater_en_out), 0);
    endtask
    task automatic t_misc;
        wr(`JSS_A_CTRL, 16'h0003);
        repeat (3) @(posedge mclk_in);
        check("vopen", 32'(valve_out), 1);
        rdck("vpos", `JSS_A_CTRL, 16'h0001);
        wr(`JSS_A_CTRL, 16'h0002);
        wr(`JSS_A_CTRL, 16'h0008);
        repeat (20) @(posedge mclk_in);
        wr(`JSS_A_CTRL, 16'h0010);
        repeat (3) @(posedge mclk_in);
        check("comp", 32'(comp_on_out), 0);
        rdck("cstat", `JSS_A_STATUS, 16'h0000);
        wr(`JSS_A_PRESS, 16'h0064);
        wr(`JSS_A_CTRL, 16'h0020);
        rdck("pup", `JSS_A_PRESS, 16'h0065);
        wr(`JSS_A_CTRL, 16'h0040);
        wr(`JSS_A_CTRL, 16'h0040);
        rdck("pdn", `JSS_A_PRESS, 16'h0063);
        wr(`JSS_A_SERIAL, 16'h0014);
        rdck("ser", `JSS_A_SERIAL, 16'h0014);
        wr(`JSS_A_SERIAL, 16'h002c);
        rdck("ser7", `JSS_A_SERIAL, 16'h002c);
        wr(`JSS_A_SERIAL, 16'h001d);
        rdck("serbad", `JSS_A_SERIAL, 16'h0000);
    endtask
    initial
    begin
        repeat (6) @(posedge mclk_in);
        rstn_in <= 1'b1;
        repeat (3) @(posedge mclk_in);
        check("heat", 32'(heater_en_out), 1);
        check("idle", 32'(firing_out), 0);
        rdck("serdef", `JSS_A_SERIAL, `JSS_SER_RESET);
        t_burst();
        t_held();
        t_stop();
        t_idle();
        t_heater();
        t_misc();
        give_verdict();
    end
endmodule // testbench
